// File: hw/twe_event_bank.sv
// twe_event_bank: group-7 trap and wake event register bank
// Overview of operation
// - control b bits 1:0 zero, 4:2 storage
// - control b bit 5 reads zero always
// - writing one to bit 5 raises sleep trap
// - control b bits 7:6 read zero, ignored
// - trap status reports each source's event
// - trap status: one clears, zero keeps
// - trap enable gates source onto trap output
// - trap bits: lines 34-37, keyboard, sleep, 62
// - wake status records regardless of enables
// - wake events set status; bits 4-6 reserved
// - wake status reset only by standby reset
// - wake status: one clears, zero keeps
// - wake enable gates status onto wake pin
// - control a bit 0 storage, rest zero
// - trap pin inactive unless group trap enabled
`timescale 1ns/1ps
module twe_event_bank (
  // clock and resets
  input wire logic clk,
  input wire logic rst_n,
  input wire logic stby_rst_n,
  // avalon-mm slave
  input wire logic read,
  input wire logic write,
  input wire logic [twe_pkg::TWE_ADDR_W-1:0] address,
  input wire logic [twe_pkg::TWE_DATA_W-1:0] writedata,
  input wire logic [3:0] byteenable,
  output logic [twe_pkg::TWE_DATA_W-1:0] readdata,
  output logic waitrequest,
  // event sources, one-cycle pulses
  input wire twe_pkg::twe_src_s trap_src,
  input wire twe_pkg::twe_src_s wake_src,
  // controls kept in other register groups
  input wire logic trap_output_enable,
  input wire logic trap_pin_push_pull,
  input wire logic wake_global_enable,
  // outputs toward the host chipset
  output logic group_trap_out_n,
  output logic trap_pin_n_o,
  output logic trap_pin_n_oe,
  output logic wake_event_pin_n_o,
  output logic wake_event_pin_n_oe,
  output logic sleep_enable_trap,
  output logic pm_control_a_bit0,
  output logic [2:0] pm_control_b_field
);
  import twe_pkg::*;

  // bus request carrier
  twe_bus_req_s req;
  // one-hot register select
  typedef enum logic [6:0] {
    TWE_SEL_NONE = 7'b0000001,
    TWE_SEL_PMA = 7'b0000010,
    TWE_SEL_PMB = 7'b0000100,
    TWE_SEL_TSTS = 7'b0001000,
    TWE_SEL_TEN = 7'b0010000,
    TWE_SEL_WSTS = 7'b0100000,
    TWE_SEL_WEN = 7'b1000000
  } twe_sel_e;

  twe_sel_e sel; // decoded register
  logic fire; // access completes this edge
  logic wr_fire; // write takes effect this edge
  logic [7:0] wbyte; // low byte of write data
  logic [TWE_DATA_W-1:0] rdata_mux; // read value before capture

  logic [7:0] pm_control_a_r; // first control register
  logic [7:0] pm_control_b_r; // second control register
  logic [7:0] trap_en_r; // trap enables
  logic [7:0] wake_en_r; // wake enables
  logic [7:0] trap_sts; // trap status from bank
  logic [7:0] wake_sts; // wake status from bank
  logic [7:0] trap_set; // trap set pulses
  logic [7:0] wake_set; // wake set pulses
  logic [7:0] trap_clr; // trap clear pulses
  logic [7:0] wake_clr; // wake clear pulses
  logic trap_any; // group trap active
  logic wake_any; // some enabled wake pending
  logic sleep_trig; // write of one to sleep bit
  logic trap_active; // trap pin asserted
  logic wake_active; // wake pin asserted
  logic wr_pma; // completed write to control a
  logic wr_pmb; // completed write to control b
  logic wr_tsts; // completed write to trap status
  logic wr_ten; // completed write to trap enable
  logic wr_wsts; // completed write to wake status
  logic wr_wen; // completed write to wake enable

  // word address from byte address; aligned words only
  function automatic twe_sel_e twe_decode(input logic [TWE_ADDR_W-1:0] a);
    twe_sel_e s;
    s = TWE_SEL_NONE;
    // unaligned addresses decode to no register
    if (a[1:0] == 2'b00) begin
      case (a[TWE_ADDR_W-1:2])
        7'(TWE_IDX_PM_CONTROL_A): s = TWE_SEL_PMA;
        7'(TWE_IDX_PM_CONTROL_B): s = TWE_SEL_PMB;
        7'(TWE_IDX_TRAP_STS_G7): s = TWE_SEL_TSTS;
        7'(TWE_IDX_TRAP_EN_G7): s = TWE_SEL_TEN;
        7'(TWE_IDX_WAKE_STS_G7): s = TWE_SEL_WSTS;
        7'(TWE_IDX_WAKE_EN_G7): s = TWE_SEL_WEN;
        default: s = TWE_SEL_NONE;
      endcase
    end
    return s;
  endfunction

  // map a source struct onto the eight status bit positions
  // positions 6:5 are left to other sources or stay zero
  function automatic logic [7:0] twe_map(input twe_src_s s, input logic kbd_used);
    return {s.general_line_62, 1'b0, 1'b0, s.keyboard_output_line & kbd_used,
            s.general_line_37, s.general_line_36, s.general_line_35, s.general_line_34};
  endfunction

  // write strobe for one decoded register
  function automatic logic twe_hit(input logic wr, input twe_sel_e cur, input twe_sel_e want);
    return wr && (cur == want);
  endfunction

  // gather bus signals into the carrier
  always_comb begin
    req.read = read;
    // read wins when both strobes are high
    req.write = write & ~read;
    req.address = address;
    req.writedata = writedata;
    req.byteenable = byteenable;
  end

  assign sel = twe_decode(req.address);
  assign wbyte = req.writedata[7:0];
  // only lane 0 holds register bits
  assign wr_fire = fire & req.write & req.byteenable[0];
  // per-register write strobes, valid only at the edge ending the cycle after the wait
  assign wr_pma = twe_hit(wr_fire, sel, TWE_SEL_PMA);
  assign wr_pmb = twe_hit(wr_fire, sel, TWE_SEL_PMB);
  assign wr_tsts = twe_hit(wr_fire, sel, TWE_SEL_TSTS);
  assign wr_ten = twe_hit(wr_fire, sel, TWE_SEL_TEN);
  assign wr_wsts = twe_hit(wr_fire, sel, TWE_SEL_WSTS);
  assign wr_wen = twe_hit(wr_fire, sel, TWE_SEL_WEN);

  // handshake and read capture
  twe_avmm_resp u_resp (
    .clk(clk),
    .rst_n(rst_n),
    .req_i(req.read | req.write),
    .rdata_i(rdata_mux),
    .waitrequest(waitrequest),
    .readdata(readdata),
    .fire_o(fire)
  );

  // read multiplexer; unmapped addresses read zero
  always_comb begin
    rdata_mux = '0;
    // control register bits outside their storage masks are masked on the way out
    case (sel)
      TWE_SEL_PMA: rdata_mux[7:0] = pm_control_a_r & TWE_PMA_RW_MASK;
      TWE_SEL_PMB: rdata_mux[7:0] = pm_control_b_r & TWE_PMB_RW_MASK;
      TWE_SEL_TSTS: rdata_mux[7:0] = trap_sts;
      TWE_SEL_TEN: rdata_mux[7:0] = trap_en_r;
      TWE_SEL_WSTS: rdata_mux[7:0] = wake_sts;
      TWE_SEL_WEN: rdata_mux[7:0] = wake_en_r;
      TWE_SEL_NONE: rdata_mux = '0;
      default: rdata_mux = '0;
    endcase
  end

  // first control register, bit 0 only
  always_ff @(posedge clk or negedge stby_rst_n) begin
    if (!stby_rst_n) begin
      pm_control_a_r <= TWE_RST_PM_CONTROL_A;
    end else if (wr_pma) begin
      pm_control_a_r <= wbyte & TWE_PMA_RW_MASK;
    end
  end

  // second control register, bits 4:2 only; bit 5 never stored
  always_ff @(posedge clk or negedge stby_rst_n) begin
    if (!stby_rst_n) begin
      pm_control_b_r <= TWE_RST_PM_CONTROL_B;
    end else if (wr_pmb) begin
      pm_control_b_r <= wbyte & TWE_PMB_RW_MASK;
    end
  end

  // write of one to the sleep bit is a trap event; zero does nothing
  // the sleep bit is never stored, so control b always reads zero there
  assign sleep_trig = wr_pmb & wbyte[TWE_PMB_SLEEP_BIT];

  // sleep trap pulse also seen outside
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sleep_enable_trap <= 1'b0;
    end else begin
      sleep_enable_trap <= sleep_trig;
    end
  end

  // trap enable register; reserved bit 6 held at zero
  always_ff @(posedge clk or negedge stby_rst_n) begin
    if (!stby_rst_n) begin
      trap_en_r <= TWE_RST_TRAP_EN_G7;
    end else if (wr_ten) begin
      trap_en_r <= wbyte & TWE_TRAP_IMPL_MASK;
    end
  end

  // wake enable register; reserved bits 6:4 held at zero
  always_ff @(posedge clk or negedge stby_rst_n) begin
    if (!stby_rst_n) begin
      wake_en_r <= TWE_RST_WAKE_EN_G7;
    end else if (wr_wen) begin
      wake_en_r <= wbyte & TWE_WAKE_IMPL_MASK;
    end
  end

  // trap sets: lines, keyboard, sleep trigger
  always_comb begin
    trap_set = twe_map(trap_src, 1'b1);
    trap_set[TWE_TRAP_SLEEP_BIT] = sleep_trig;
  end

  // wake sets recorded regardless of any enable
  assign wake_set = twe_map(wake_src, 1'b0);

  // write-one clears
  assign trap_clr = wr_tsts ? wbyte : 8'h00;
  assign wake_clr = wr_wsts ? wbyte : 8'h00;

  // trap status flags
  // status survives the bus reset; of the two resets only the standby reset clears it
  twe_sticky_bank #(
    .W(TWE_REG_W),
    .IMPL_MASK(TWE_TRAP_IMPL_MASK),
    .RST_VAL(TWE_RST_TRAP_STS_G7)
  ) u_trap (
    .clk(clk),
    .rst_n(stby_rst_n),
    .set_i(trap_set),
    .clr_i(trap_clr),
    .en_i(trap_en_r),
    .sts_o(trap_sts),
    .any_o(trap_any)
  );

  // wake status flags, standby reset only
  twe_sticky_bank #(
    .W(TWE_REG_W),
    .IMPL_MASK(TWE_WAKE_IMPL_MASK),
    .RST_VAL(TWE_RST_WAKE_STS_G7)
  ) u_wake (
    .clk(clk),
    .rst_n(stby_rst_n),
    .set_i(wake_set),
    .clr_i(wake_clr),
    .en_i(wake_en_r),
    .sts_o(wake_sts),
    .any_o(wake_any)
  );

  // group trap and pin activity
  // the trap pin also needs its enable from another register group
  assign trap_active = trap_any & trap_output_enable;
  assign wake_active = wake_any & wake_global_enable;

  // group trap output, idle high
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      group_trap_out_n <= 1'b1;
    end else begin
      group_trap_out_n <= ~trap_any;
    end
  end

  // trap pin: push-pull drives high when idle, open drain floats
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      trap_pin_n_o <= 1'b1;
      trap_pin_n_oe <= 1'b0;
    end else begin
      trap_pin_n_o <= ~trap_active;
      trap_pin_n_oe <= trap_active | trap_pin_push_pull;
    end
  end

  // wake pin is open drain, pulled low while an enabled wake is pending and wake_global_enable is high
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wake_event_pin_n_o <= 1'b1;
      wake_event_pin_n_oe <= 1'b0;
    end else begin
      wake_event_pin_n_o <= 1'b0;
      wake_event_pin_n_oe <= wake_active;
    end
  end

  // stored control fields to surrounding logic
  // these fields are used by neighbouring power logic only
  assign pm_control_a_bit0 = pm_control_a_r[0];
  assign pm_control_b_field = pm_control_b_r[4:2];
endmodule

// File: hw/twe_pkg.sv
// twe_pkg: constants and carrier types for the trap and wake event bank
package twe_pkg;

  // bus geometry
  localparam int unsigned TWE_ADDR_W = 9;
  localparam int unsigned TWE_DATA_W = 32;
  localparam int unsigned TWE_REG_W = 8;

  // register indexes; byte address is four times the index
  localparam logic [7:0] TWE_IDX_PM_CONTROL_A = 8'h60;
  localparam logic [7:0] TWE_IDX_PM_CONTROL_B = 8'h61;
  localparam logic [7:0] TWE_IDX_TRAP_STS_G7 = 8'h64;
  localparam logic [7:0] TWE_IDX_TRAP_EN_G7 = 8'h66;
  localparam logic [7:0] TWE_IDX_WAKE_STS_G7 = 8'h68;
  localparam logic [7:0] TWE_IDX_WAKE_EN_G7 = 8'h6c;

  // reset values
  localparam logic [7:0] TWE_RST_PM_CONTROL_A = 8'h00;
  localparam logic [7:0] TWE_RST_PM_CONTROL_B = 8'h00;
  localparam logic [7:0] TWE_RST_TRAP_STS_G7 = 8'h00;
  localparam logic [7:0] TWE_RST_TRAP_EN_G7 = 8'h00;
  localparam logic [7:0] TWE_RST_WAKE_STS_G7 = 8'h00;
  localparam logic [7:0] TWE_RST_WAKE_EN_G7 = 8'h00;

  // field layouts
  localparam logic [7:0] TWE_PMA_RW_MASK = 8'h01;
  localparam logic [7:0] TWE_PMB_RW_MASK = 8'h1c;
  localparam int unsigned TWE_PMB_SLEEP_BIT = 5;
  localparam int unsigned TWE_TRAP_SLEEP_BIT = 5;
  localparam logic [7:0] TWE_TRAP_IMPL_MASK = 8'hbf;
  localparam logic [7:0] TWE_WAKE_IMPL_MASK = 8'h8f;

  // event sources from the general-purpose and keyboard logic
  typedef struct packed {
    logic general_line_62;
    logic keyboard_output_line;
    logic general_line_37;
    logic general_line_36;
    logic general_line_35;
    logic general_line_34;
  } twe_src_s;

  // avalon-mm request as seen by the slave
  typedef struct packed {
    logic read;
    logic write;
    logic [TWE_ADDR_W-1:0] address;
    logic [TWE_DATA_W-1:0] writedata;
    logic [3:0] byteenable;
  } twe_bus_req_s;

endpackage

// File: hw/twe_sticky_bank.sv
// twe_sticky_bank: sticky event flags with write-one clear and enable gating
`timescale 1ns/1ps
module twe_sticky_bank #(
  parameter int unsigned W = 8,
  parameter logic [W-1:0] IMPL_MASK = '1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [W-1:0] set_i,
  input wire logic [W-1:0] clr_i,
  input wire logic [W-1:0] en_i,
  output logic [W-1:0] sts_o,
  output logic any_o
);

  logic [W-1:0] sts_r; // sticky flags
  logic [W-1:0] sts_nxt; // next flag value

  // clear first, then set, so a same-cycle event survives
  always_comb begin
    sts_nxt = ((sts_r & ~clr_i) | set_i) & IMPL_MASK;
  end

  // flag storage
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sts_r <= RST_VAL;
    end else begin
      sts_r <= sts_nxt;
    end
  end

  assign sts_o = sts_r;
  // any enabled pending flag
  assign any_o = |(sts_r & en_i);
endmodule

// File: hw/twe_avmm_resp.sv
// twe_avmm_resp: avalon-mm waitrequest and read data timing
`timescale 1ns/1ps
module twe_avmm_resp (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic req_i,
  input wire logic [twe_pkg::TWE_DATA_W-1:0] rdata_i,
  output logic waitrequest,
  output logic [twe_pkg::TWE_DATA_W-1:0] readdata,
  output logic fire_o
);
  import twe_pkg::*;

  logic ack_r; // second cycle of a request
  logic [TWE_DATA_W-1:0] readdata_r; // captured read data

  // one wait cycle per request, then the answer
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ack_r <= 1'b0;
    end else begin
      ack_r <= req_i & ~ack_r;
    end
  end

  // read data captured during the wait cycle, stands at the release edge
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      readdata_r <= '0;
    end else if (req_i && !ack_r) begin
      readdata_r <= rdata_i;
    end
  end

  assign waitrequest = req_i & ~ack_r;
  assign fire_o = req_i & ack_r;
  assign readdata = readdata_r;
endmodule

// File: tb/twe_event_bank_properties.sv
// checker: bus timing, read masks and pin relations of the event bank
`timescale 1ns/1ps
module twe_event_bank_properties (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic read,
  input wire logic write,
  input wire logic [8:0] address,
  input wire logic [31:0] writedata,
  input wire logic [3:0] byteenable,
  input wire logic [31:0] readdata,
  input wire logic waitrequest,
  input wire logic trap_output_enable,
  input wire logic wake_global_enable,
  input wire logic trap_pin_n_o,
  input wire logic trap_pin_n_oe,
  input wire logic wake_event_pin_n_o,
  input wire logic wake_event_pin_n_oe,
  input wire logic sleep_enable_trap,
  input wire logic pm_control_a_bit0,
  input wire logic [2:0] pm_control_b_field
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  // write of one to the sleep bit completing now, as a plain signal
  logic sleep_wr;
  assign sleep_wr = write && !read && !waitrequest && byteenable[0] && address == 9'h184
    && writedata[5];
  // read completing at this edge
  sequence s_rd(a);
    read && !waitrequest && address == a;
  endsequence
  // write of one to the sleep bit completing at this edge
  sequence s_sleep;
    write && !read && !waitrequest && byteenable[0] && address == 9'h184 && writedata[5];
  endsequence
  AST_WAIT_FIRST: assert property ($rose(read || write) |-> waitrequest)
    else $error("request start without wait state");
  AST_WAIT_ONE: assert property ((read || write) && waitrequest |=> !waitrequest)
    else $error("more than one wait state");
  AST_PMA_RD: assert property (s_rd(9'h180) |-> readdata[7:0] == {7'h0, pm_control_a_bit0})
    else $error("control a read wrong");
  AST_PMB_RD: assert property (s_rd(9'h184) |-> readdata[7:0] == {3'h0, pm_control_b_field, 2'h0})
    else $error("control b read wrong");
  AST_TRAP_EN_RSV: assert property (s_rd(9'h198) |-> readdata[6] == 1'b0)
    else $error("reserved trap enable bit set");
  AST_WAKE_RSV: assert property (s_rd(9'h1a0) |-> readdata[6:4] == 3'h0)
    else $error("reserved wake status bits set");
  AST_SLEEP: assert property (s_sleep |=> sleep_enable_trap)
    else $error("sleep trap pulse missing");
  AST_SLEEP_CAUSE: assert property (sleep_enable_trap |-> $past(sleep_wr))
    else $error("sleep trap pulse without write");
  AST_TRAP_IDLE: assert property ((!trap_output_enable) [*2] |-> trap_pin_n_o)
    else $error("trap pin active while disabled");
  AST_TRAP_DRV: assert property (!trap_pin_n_o |-> trap_pin_n_oe)
    else $error("trap pin low but not driven");
  AST_WAKE_GATE: assert property ((!wake_global_enable) [*2] |-> !wake_event_pin_n_oe)
    else $error("wake pin driven while disabled");
  AST_WAKE_LOW: assert property (wake_event_pin_n_oe |-> !wake_event_pin_n_o)
    else $error("wake pin driven high");
endmodule
bind twe_event_bank twe_event_bank_properties u_props (.clk, .rst_n, .read, .write, .address,
  .writedata, .byteenable, .readdata, .waitrequest, .trap_output_enable, .wake_global_enable,
  .trap_pin_n_o, .trap_pin_n_oe, .wake_event_pin_n_o, .wake_event_pin_n_oe, .sleep_enable_trap,
  .pm_control_a_bit0, .pm_control_b_field);

// File: tb/twe_host_model.sv
// host chipset side: trap and wake lines with board pull-ups
`timescale 1ns/1ps
module twe_host_model (
  input wire logic trap_pin_n_o,
  input wire logic trap_pin_n_oe,
  input wire logic wake_event_pin_n_o,
  input wire logic wake_event_pin_n_oe,
  output logic trap_line_n,
  output logic wake_line_n
);
  // a released pin floats to the pull-up level
  assign trap_line_n = trap_pin_n_oe ? trap_pin_n_o : 1'b1;
  assign wake_line_n = wake_event_pin_n_oe ? wake_event_pin_n_o : 1'b1;
endmodule

// File: tb/tb_trap_wake_event_bank_group7.sv
// self-checking bench for the group-7 trap and wake event bank
`timescale 1ns/1ps
module tb_trap_wake_event_bank_group7;
  import twe_pkg::*;
  logic clk = 0, rst_n = 0, stby_rst_n = 0, read = 0, write = 0;
  logic [8:0] address = '0;
  logic [31:0] writedata = '0, readdata;
  logic [3:0] byteenable = 4'hf;
  twe_src_s trap_src = '0, wake_src = '0;
  logic trap_output_enable = 0, trap_pin_push_pull = 0, wake_global_enable = 0;
  logic waitrequest, group_trap_out_n, trap_pin_n_o, trap_pin_n_oe, sleep_enable_trap;
  logic wake_event_pin_n_o, wake_event_pin_n_oe, pm_control_a_bit0, trap_line_n, wake_line_n;
  logic [2:0] pm_control_b_field;
  logic [7:0] q;
  int bad_count = 0, cmp_count = 0, i, k;
  int img[7]; // reference register images
  int msk[7] = '{1, 'h1c, 0, 'hbf, 0, 'h8f, 0}; // storable bits
  logic [8:0] adr[7] = '{9'h180, 9'h184, 9'h190, 9'h198, 9'h1a0, 9'h1b0, 9'h1fc};
  twe_event_bank u_dut (.*);
  twe_host_model u_host (.*);
  // 200 mhz clock
  always #2.5 clk = ~clk;
  // count, report and finish
  task automatic print_verdict;
    $display("compares %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  // compare a register byte
  task automatic chk_reg(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp) begin
      bad_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // compare a pin level
  task automatic chk_pin(input logic got, input logic exp);
    chk_reg({7'h0, got}, {7'h0, exp});
  endtask
  // reference write effect
  task automatic mdl_wr(input int j, input logic [7:0] d);
    if (j == 2 || j == 4) img[j] &= ~d;
    else img[j] = d & msk[j];
    if (j == 1 && d[5]) img[2] |= 'h20;
  endtask
  // one avalon transfer held until waitrequest is seen low
  task automatic bus(input logic wr, input int j, input logic [7:0] d, input logic [3:0] be);
    int n;
    n = 0;
    @(posedge clk);
    read <= !wr;
    write <= wr;
    address <= adr[j];
    writedata <= {24'h0, d};
    byteenable <= be;
    @(posedge clk);
    while (waitrequest !== 1'b0) begin
      n++;
      if (n > 20) begin
        bad_count++;
        print_verdict();
      end
      @(posedge clk);
    end
    q = readdata[7:0];
    read <= 0;
    write <= 0;
    if (wr && be[0]) mdl_wr(j, d);
  endtask
  // read every register and check the pins
  task automatic chk_all;
    logic t, w;
    for (int j = 0; j < 7; j++) begin
      bus(0, j, 8'h0, 4'hf);
      chk_reg(q, 8'(img[j]));
    end
    repeat (3) @(posedge clk);
    t = |(img[2] & img[3]);
    w = |(img[4] & img[5]);
    chk_pin(group_trap_out_n, !t);
    chk_pin(trap_line_n, !(t && trap_output_enable));
    chk_pin(wake_line_n, !(w && wake_global_enable));
  endtask
  // main sequence
  initial begin
    k = $urandom(32'h75485d41);
    img = '{default: 0};
    repeat (10) @(posedge clk);
    rst_n <= 1;
    stby_rst_n <= 1;
    chk_all();
    $display("test reset values done");
    for (i = 0; i < 7; i++) bus(1, i, 8'hff, 4'hf);
    chk_all();
    $display("test write masks done");
    for (k = 0; k < 60; k++) begin
      @(posedge clk);
      {trap_output_enable, trap_pin_push_pull, wake_global_enable} <= 3'($urandom);
      trap_src <= 6'($urandom & $urandom);
      wake_src <= 6'($urandom & $urandom);
      i = $urandom % 7;
      bus(1, i, 8'($urandom), 4'(($urandom % 4) ? 15 : 14));
      img[2] |= {trap_src[5], 2'b00, trap_src[4:0]};
      img[4] |= {wake_src[5], 3'b000, wake_src[3:0]};
      trap_src <= '0;
      wake_src <= '0;
      chk_all();
    end
    $display("test random traffic done");
    @(posedge clk);
    trap_src <= '1;
    wake_src <= '1;
    @(posedge clk);
    trap_src <= '0;
    wake_src <= '0;
    img[2] |= 'h9f;
    img[4] |= 'h8f;
    rst_n <= 0;
    repeat (3) @(posedge clk);
    rst_n <= 1;
    chk_all();
    $display("test bus reset done");
    stby_rst_n <= 0;
    repeat (3) @(posedge clk);
    stby_rst_n <= 1;
    img = '{default: 0};
    chk_all();
    $display("test standby reset done");
    print_verdict();
  end
endmodule
